// ---- core/aop_postproc.sv ----
`timescale 1ns/1ps
// Contract
// - Three alarms, type codes 0 to 12.
// - Per-alarm hysteresis 0.1 to 999.2, default 0.2.
// - Decimal point zero scales as one digit.
// - Configuration writes accepted only while stopped.
// - Type zero disables all alarm functions.
// - Standby alarm waits for leave then re-entry.
// - Assertion clears standby for later entries.
// - Standby re-armed on start, edits, bank, type.
// - Latched alarm holds until cancel or reset.
// - Polarity one inverts output, zero passes.
// - Output held open three seconds after power-up.
// - Open-in-alarm only for control-output alarms.
// - ON/OFF delays 0 to 999 s, in status.
// - ON delay also runs after power-up, reset.
// - Change passes only when outlasting its delay.
// - Reverting change restarts the delay timer.
// - Reference is ramping or final set point.
// - Selection only for deviation, ramp on, tuning off.
// - Current sensor selectors 0 off, 1 to 4.
module aop_postproc #(
  parameter int TICK_CYC = aop_pkg::TICK_CYC_DEF, // Cycles per delay step.
  parameter int HOLD_CYC = aop_pkg::HOLD_CYC_DEF  // Cycles of power-up hold.
) (
  // Clock and reset.
  input  wire  logic               clk_i,
  input  wire  logic               rst_i,
  // Wishbone slave.
  input  wire  logic               wb_cyc_i,
  input  wire  logic               wb_stb_i,
  input  wire  logic               wb_we_i,
  input  wire  logic [7:0]         wb_adr_i,
  input  wire  logic [3:0]         wb_sel_i,
  input  wire  logic [31:0]        wb_dat_i,
  output logic                     wb_ack_o,
  output logic       [31:0]        wb_dat_o,
  // Process inputs.
  input  wire  aop_pkg::aop_proc_s proc_i,
  // Alarm results.
  output logic       [2:0]         alarm_out_o,
  output logic       [2:0]         alarm_status_o,
  // Current sensor selection, one-hot control output.
  output logic       [3:0]         current_sensor_one_o,
  output logic       [3:0]         current_sensor_two_o
);

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  logic                    run;        // Control operation running.
  logic                    run_q;      // Run delayed for edge detection.
  logic                    lat_cancel; // Latch cancel pulse.
  logic                    soft_rst;   // Software reset pulse.
  logic [2:0]              dp;         // Decimal point selection.
  logic [15:0]             shift;      // Input shift.
  logic [2:0]              cta1;       // First sensor assignment.
  logic [2:0]              cta2;       // Second sensor assignment.
  aop_pkg::aop_cfg_s       cfg [3];    // Alarm configurations.
  logic [31:0]             aval [3];   // Alarm values.
  logic [15:0]             hys [3];    // Hysteresis values.
  logic [9:0]              don [3];    // ON delays in seconds.
  logic [9:0]              doff [3];   // OFF delays in seconds.
  logic [2:0]              arm_wr;     // Per-alarm re-arm from writes.
  logic                    wr;         // Write taken this edge.
  logic                    rd;         // Read taken this edge.
  logic [31:0]             next_dat;   // Read data selected.
  logic [31:0]             pre_cnt;    // Step prescaler.
  logic                    tick;       // One-second step pulse.
  logic [31:0]             hold_cnt;   // Power-up hold counter.
  logic                    hold;       // Power-up hold active.
  logic signed [15:0]      sp_last;    // Set point seen last cycle.
  logic [1:0]              bank_last;  // Bank seen last cycle.
  logic                    rearm_all;  // Re-arm every standby.
  logic                    next_sta [3]; // Next status bits.
  logic                    next_out [3]; // Next output bits.
  logic                    stby_v [3];   // Standby flags for reading.

  // Byte-lane merge of a write into a register image.
  function automatic logic [31:0] wm(input logic [31:0] o, input logic [31:0] n,
                                     input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++)
    begin
      if (s[b])
      begin
        r[8*b +: 8] = n[8*b +: 8];
      end
    end
    return r;
  endfunction : wm

  // ****************************************************************
  // Wishbone handshake.
  // ****************************************************************
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
  assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

  // Acknowledge one cycle after the request, drop it the cycle after.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      if (rd)
      begin
        wb_dat_o <= next_dat;
      end
    end
  end

  // Read multiplexer; unmapped offsets read as zero.
  always_comb
  begin
    next_dat = 32'h0000_0000;
    if (wb_adr_i[7:4] == 4'h0)
    begin
      unique case (wb_adr_i[3:2])
        aop_pkg::OFS_CTRL[3:2]:  next_dat = {25'h0, dp, 3'h0, run};
        aop_pkg::OFS_SHIFT[3:2]: next_dat = {16'h0, shift};
        aop_pkg::OFS_STAT[3:2]:
        begin
          for (int i = 0; i < 3; i++)
          begin
            next_dat[i] = alarm_status_o[i];
            next_dat[aop_pkg::STAT_OUT + i] = alarm_out_o[i];
            next_dat[aop_pkg::STAT_STBY + i] = stby_v[i];
          end
        end
        aop_pkg::OFS_CTA[3:2]:   next_dat = {25'h0, cta2, 1'b0, cta1};
      endcase
    end
    for (int i = 0; i < 3; i++)
    begin
      if (wb_adr_i[7:4] == aop_pkg::ALM_BASE + 4'(i))
      begin
        unique case (wb_adr_i[3:2])
          aop_pkg::SUB_CFG: next_dat = {24'h0, cfg[i]};
          aop_pkg::SUB_VAL: next_dat = aval[i];
          aop_pkg::SUB_HYS: next_dat = {16'h0, hys[i]};
          aop_pkg::SUB_DLY: next_dat = {6'h0, doff[i], 6'h0, don[i]};
        endcase
      end
    end
  end

  // ****************************************************************
  // Register writes.
  // ****************************************************************
  // Configuration is only taken while stopped; run and commands always.
  always_ff @(posedge clk_i)
  begin
    logic [31:0] n;
    if (rst_i)
    begin
      run        <= 1'b0;
      lat_cancel <= 1'b0;
      soft_rst   <= 1'b0;
      dp         <= 3'h0;
      shift      <= 16'h0000;
      cta1       <= 3'h0;
      cta2       <= 3'h0;
      arm_wr     <= 3'h0;
      for (int i = 0; i < 3; i++)
      begin
        cfg[i]  <= '{atype: aop_pkg::TYPE_RST, default: 1'b0};
        aval[i] <= 32'h0000_0000;
        hys[i]  <= aop_pkg::HYS_RST;
        don[i]  <= 10'h000;
        doff[i] <= 10'h000;
      end
    end
    else
    begin
      lat_cancel <= 1'b0;
      soft_rst   <= 1'b0;
      arm_wr     <= 3'h0;
      if (wr && wb_adr_i[7:2] == aop_pkg::OFS_CTRL[7:2])
      begin
        n = wm({25'h0, dp, 3'h0, run}, wb_dat_i, wb_sel_i);
        run        <= n[aop_pkg::CTRL_RUN];
        lat_cancel <= n[aop_pkg::CTRL_LCAN];
        soft_rst   <= n[aop_pkg::CTRL_SRST];
        if (!run)
        begin
          dp <= n[aop_pkg::CTRL_DP +: 3];
        end
      end
      if (wr && !run)
      begin
        if (wb_adr_i[7:2] == aop_pkg::OFS_SHIFT[7:2])
        begin
          n = wm({16'h0, shift}, wb_dat_i, wb_sel_i);
          shift  <= n[15:0];
          arm_wr <= 3'h7;
        end
        if (wb_adr_i[7:2] == aop_pkg::OFS_CTA[7:2])
        begin
          n = wm({25'h0, cta2, 1'b0, cta1}, wb_dat_i, wb_sel_i);
          if (n[2:0] <= aop_pkg::CTA_MAX)
          begin
            cta1 <= n[2:0];
          end
          if (n[aop_pkg::CTA_TWO +: 3] <= aop_pkg::CTA_MAX)
          begin
            cta2 <= n[aop_pkg::CTA_TWO +: 3];
          end
        end
        for (int i = 0; i < 3; i++)
        begin
          if (wb_adr_i[7:4] == aop_pkg::ALM_BASE + 4'(i))
          begin
            unique case (wb_adr_i[3:2])
              aop_pkg::SUB_CFG:
              begin
                n = wm({24'h0, cfg[i]}, wb_dat_i, wb_sel_i);
                if (n[3:0] <= aop_pkg::TYPE_MAX)
                begin
                  cfg[i] <= n[7:0];
                  if (n[3:0] != cfg[i].atype)
                  begin
                    arm_wr[i] <= 1'b1;
                  end
                end
              end
              aop_pkg::SUB_VAL:
              begin
                aval[i]   <= wm(aval[i], wb_dat_i, wb_sel_i);
                arm_wr[i] <= 1'b1;
              end
              aop_pkg::SUB_HYS:
              begin
                n = wm({16'h0, hys[i]}, wb_dat_i, wb_sel_i);
                if (n[15:0] >= aop_pkg::HYS_MIN && n[15:0] <= aop_pkg::HYS_MAX)
                begin
                  hys[i] <= n[15:0];
                end
              end
              aop_pkg::SUB_DLY:
              begin
                n = wm({6'h0, doff[i], 6'h0, don[i]}, wb_dat_i, wb_sel_i);
                if (n[9:0] <= aop_pkg::DLY_MAX)
                begin
                  don[i] <= n[9:0];
                end
                if (n[aop_pkg::DLY_OFF +: 10] <= aop_pkg::DLY_MAX)
                begin
                  doff[i] <= n[aop_pkg::DLY_OFF +: 10];
                end
              end
            endcase
          end
        end
      end
    end
  end

  // ****************************************************************
  // Timebase and power-up hold.
  // ****************************************************************
  // One-second step; a software reset restarts it with the delays.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || soft_rst)
    begin
      pre_cnt <= 32'h0000_0000;
      tick    <= 1'b0;
    end
    else if (pre_cnt == 32'(TICK_CYC - 1))
    begin
      pre_cnt <= 32'h0000_0000;
      tick    <= 1'b1;
    end
    else
    begin
      pre_cnt <= pre_cnt + 32'h0000_0001;
      tick    <= 1'b0;
    end
  end

  // Holds every alarm pin open for the first seconds after power-up.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hold_cnt <= 32'h0000_0000;
      hold     <= 1'b1;
    end
    else if (hold)
    begin
      hold_cnt <= hold_cnt + 32'h0000_0001;
      hold     <= (hold_cnt != 32'(HOLD_CYC - 1));
    end
  end

  // ****************************************************************
  // Standby re-arm events.
  // ****************************************************************
  // Control start, software reset, set point and bank changes.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      run_q     <= 1'b0;
      sp_last   <= 16'h0000;
      bank_last <= 2'h0;
    end
    else
    begin
      run_q     <= run;
      sp_last   <= proc_i.sp_target;
      bank_last <= proc_i.bank;
    end
  end

  assign rearm_all = (run & ~run_q) | soft_rst | (sp_last != proc_i.sp_target)
                   | (bank_last != proc_i.bank);

  // ****************************************************************
  // Per-alarm conditioning.
  // ****************************************************************
  for (genvar g = 0; g < 3; g++)
  begin : g_alm
    aop_pkg::aop_cfg_s  c;      // This alarm's configuration.
    logic               dev;    // Deviation type.
    logic               absv;   // Absolute-value type.
    logic               sb;     // Standby-sequence type.
    logic signed [19:0] refv;   // Comparison reference.
    logic signed [19:0] pvs;    // Scaled shifted process value.
    logic signed [19:0] th;     // Scaled upper threshold.
    logic signed [19:0] tl;     // Scaled lower threshold.
    logic signed [19:0] h;      // Hysteresis.
    logic               next_fn; // Next raw alarm function.
    logic               fn;     // Raw alarm function.
    logic               stby;   // Standby armed.
    logic               gated;  // Function after standby.
    logic               del;    // Delayed alarm.
    logic [9:0]         cnt;    // Delay steps seen.
    logic [9:0]         lim;    // Delay for the pending change.
    logic               lat;    // Latched alarm.
    logic               alm;    // Final alarm state.

    // Multiply by ten when the decimal point selection is zero.
    function automatic logic signed [19:0] scl(input logic signed [19:0] v,
                                               input logic z);
      return z ? (v <<< 3) + (v <<< 1) : v;
    endfunction : scl

    assign c    = cfg[g];
    assign dev  = (c.atype >= aop_pkg::T_ULB) && (c.atype <= aop_pkg::T_LOS);
    assign absv = (c.atype >= aop_pkg::T_AUP) && (c.atype <= aop_pkg::T_ALOS);
    assign sb   = (c.atype == aop_pkg::T_ULBS) || (c.atype == aop_pkg::T_UPS)
               || (c.atype == aop_pkg::T_LOS) || (c.atype == aop_pkg::T_AUPS)
               || (c.atype == aop_pkg::T_ALOS);

    // Threshold build-up and comparison with hysteresis.
    always_comb
    begin
      refv = (c.sp_sel && dev && proc_i.ramp_en && !proc_i.self_tune)
           ? 20'(proc_i.sp_target) : 20'(proc_i.sp_ramp);
      th = absv ? 20'($signed(aval[g][15:0]))
                : refv + 20'($signed(aval[g][15:0]));
      if (c.atype == aop_pkg::T_ULB || c.atype == aop_pkg::T_RNG
          || c.atype == aop_pkg::T_ULBS)
      begin
        tl = refv - 20'($signed(aval[g][31:16]));
      end
      else
      begin
        tl = th;
      end
      pvs = scl(20'(proc_i.pv) + 20'($signed(shift)), dp == 3'h0);
      th  = scl(th, dp == 3'h0);
      tl  = scl(tl, dp == 3'h0);
      h   = {4'h0, hys[g]};
      unique case (c.atype)
        aop_pkg::T_UP, aop_pkg::T_UPS, aop_pkg::T_AUP, aop_pkg::T_AUPS:
          next_fn = fn ? !(pvs < th - h) : (pvs > th);
        aop_pkg::T_LO, aop_pkg::T_LOS, aop_pkg::T_ALO, aop_pkg::T_ALOS:
          next_fn = fn ? !(pvs > tl + h) : (pvs < tl);
        aop_pkg::T_ULB, aop_pkg::T_ULBS:
          next_fn = fn ? !((pvs < th - h) && (pvs > tl + h)) : ((pvs > th) || (pvs < tl));
        aop_pkg::T_RNG:
          next_fn = fn ? !((pvs > th + h) || (pvs < tl - h)) : ((pvs <= th) && (pvs >= tl));
        default:
          next_fn = 1'b0;
      endcase
    end

    // Raw function state; type zero keeps it off.
    always_ff @(posedge clk_i)
    begin
      if (rst_i || c.atype == aop_pkg::T_OFF)
      begin
        fn <= 1'b0;
      end
      else
      begin
        fn <= next_fn;
      end
    end

    // Standby: armed by events, dropped when the next function value is off.
    always_ff @(posedge clk_i)
    begin
      if (rst_i || rearm_all || arm_wr[g])
      begin
        stby <= 1'b1;
      end
      else if (!next_fn)
      begin
        stby <= 1'b0;
      end
    end

    assign gated = fn & ~(sb & stby);

    // ON/OFF delay; a reverting change clears the step count.
    assign lim = gated ? don[g] : doff[g];
    always_ff @(posedge clk_i)
    begin
      if (rst_i || soft_rst || c.atype == aop_pkg::T_OFF)
      begin
        del <= 1'b0;
        cnt <= 10'h000;
      end
      else if (gated == del)
      begin
        cnt <= 10'h000;
      end
      else if (lim == 10'h000)
      begin
        del <= gated;
      end
      else if (tick)
      begin
        if (cnt == lim)
        begin
          del <= gated;
          cnt <= 10'h000;
        end
        else
        begin
          cnt <= cnt + 10'h001;
        end
      end
    end

    // Latch; a new assertion wins over a cancel in the same cycle.
    always_ff @(posedge clk_i)
    begin
      if (rst_i || c.atype == aop_pkg::T_OFF)
      begin
        lat <= 1'b0;
      end
      else if (c.latch && del)
      begin
        lat <= 1'b1;
      end
      else if (lat_cancel || soft_rst || !c.latch)
      begin
        lat <= 1'b0;
      end
    end

    assign alm         = del | lat;
    assign stby_v[g]   = stby & sb;
    assign next_sta[g] = alm;
    assign next_out[g] = !hold && c.atype != aop_pkg::T_OFF
                       && (alm ^ (c.open_alm & c.ctl_assigned));
  end

  // ****************************************************************
  // Output registers.
  // ****************************************************************
  // Alarm pins, status and sensor selections all leave from flops.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      alarm_out_o          <= 3'h0;
      alarm_status_o       <= 3'h0;
      current_sensor_one_o <= 4'h0;
      current_sensor_two_o <= 4'h0;
    end
    else
    begin
      for (int i = 0; i < 3; i++)
      begin
        alarm_out_o[i]    <= next_out[i];
        alarm_status_o[i] <= next_sta[i];
      end
      current_sensor_one_o <= (cta1 == 3'h0) ? 4'h0 : 4'h1 << (cta1 - 3'h1);
      current_sensor_two_o <= (cta2 == 3'h0) ? 4'h0 : 4'h1 << (cta2 - 3'h1);
    end
  end

endmodule : aop_postproc

// ---- core/aop_pkg.sv ----
// ****************************************************************
// Alarm output postprocessor constants and types.
// ****************************************************************
package aop_pkg;

  // ****************************************************************
  // Register map, byte offsets on the Wishbone bus.
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL  = 8'h00; // Run and commands.
  localparam logic [7:0] OFS_SHIFT = 8'h04; // Input shift.
  localparam logic [7:0] OFS_STAT  = 8'h08; // Alarm status.
  localparam logic [7:0] OFS_CTA   = 8'h0C; // Current sensor assignment.
  localparam logic [3:0] ALM_BASE  = 4'h1;  // Alarm n block at (n+1)*16.
  localparam logic [1:0] SUB_CFG   = 2'h0;  // Alarm configuration.
  localparam logic [1:0] SUB_VAL   = 2'h1;  // Alarm value, low X/H, high L.
  localparam logic [1:0] SUB_HYS   = 2'h2;  // Hysteresis.
  localparam logic [1:0] SUB_DLY   = 2'h3;  // ON and OFF delays.

  // ****************************************************************
  // Field positions.
  // ****************************************************************
  localparam int CTRL_RUN   = 0;  // Control operation running.
  localparam int CTRL_LCAN  = 1;  // Latch cancel command.
  localparam int CTRL_SRST  = 2;  // Software reset command.
  localparam int CTRL_DP    = 4;  // Decimal point selection, 3 bits.
  localparam int CTA_TWO    = 4;  // Second sensor field, 3 bits.
  localparam int DLY_OFF    = 16; // OFF delay field, 10 bits.
  localparam int STAT_OUT   = 4;  // Output pin states, 3 bits.
  localparam int STAT_STBY  = 8;  // Standby flags, 3 bits.

  // ****************************************************************
  // Reset values and limits.
  // ****************************************************************
  localparam logic [3:0]  TYPE_RST = 4'h2;    // Upper limit.
  localparam logic [3:0]  TYPE_MAX = 4'hC;    // Highest type code.
  localparam logic [15:0] HYS_RST  = 16'h0002; // 0.2 units.
  localparam logic [15:0] HYS_MIN  = 16'h0001; // 0.1 units.
  localparam logic [15:0] HYS_MAX  = 16'h2708; // 999.2 units.
  localparam logic [9:0]  DLY_MAX  = 10'h3E7;  // 999 seconds.
  localparam logic [2:0]  CTA_MAX  = 3'h4;     // Control output 4.

  // ****************************************************************
  // Alarm type codes.
  // ****************************************************************
  localparam logic [3:0] T_OFF = 4'h0, T_ULB = 4'h1, T_UP = 4'h2, T_LO = 4'h3;
  localparam logic [3:0] T_RNG = 4'h4, T_ULBS = 4'h5, T_UPS = 4'h6, T_LOS = 4'h7;
  localparam logic [3:0] T_AUP = 4'h8, T_ALO = 4'h9, T_AUPS = 4'hA, T_ALOS = 4'hB;

  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int CLK_HZ       = 10_000_000;     // Clock rate in hertz.
  localparam int TICK_S       = 1;              // Delay step in seconds.
  localparam int HOLD_S       = 3;              // Power-up hold in seconds.
  localparam int TICK_CYC_DEF = CLK_HZ * TICK_S; // Cycles per step.
  localparam int HOLD_CYC_DEF = CLK_HZ * HOLD_S; // Cycles of hold.

  // ****************************************************************
  // Carriers.
  // ****************************************************************
  typedef struct packed {
    logic ctl_assigned; // Alarm drives a control output.
    logic sp_sel;       // 1 compares deviation types against the final set point while ramp_en is on and self_tune off.
    logic open_alm;     // 1 opens the contact in alarm when ctl_assigned is also 1.
    logic latch;        // 1 latches an asserted alarm.
    logic [3:0] atype;  // Alarm type code.
  } aop_cfg_s;

  typedef struct packed {
    logic signed [15:0] pv;        // Process value.
    logic signed [15:0] sp_ramp;   // Ramping set point.
    logic signed [15:0] sp_target; // Final set point.
    logic [1:0]         bank;      // Active bank.
    logic               ramp_en;   // Set-point ramping enabled.
    logic               self_tune; // Self-tuning function enabled.
  } aop_proc_s;

endpackage : aop_pkg

// ---- verif/aop_postproc_asserts.sv ----
`timescale 1ns/1ps
// Checks the bus handshake, the power-up hold and the sensor selectors.
module aop_postproc_asserts #(
  parameter int TICK_CYC = 10,
  parameter int HOLD_CYC = 20
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_ack_o,
  input  wire logic [31:0] wb_dat_o,
  input  wire logic [2:0]  alarm_out_o,
  input  wire logic [3:0]  current_sensor_one_o,
  input  wire logic [3:0]  current_sensor_two_o
);
  int   hold_cnt; // Cycles since reset release.
  logic req;      // A request not yet answered.
  logic wreq;     // A write being taken.
  assign req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wreq = req && wb_we_i;
  // Counts up to the end of the power-up hold.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      hold_cnt <= 0;
    else if (hold_cnt < HOLD_CYC)
      hold_cnt <= hold_cnt + 1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack; req |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_ack_why; $rose(wb_ack_o) |-> $past(req); endproperty
  a_ack_why: assert property (p_ack_why) else $error("ack without request");
  property p_dat; $changed(wb_dat_o) |-> wb_ack_o; endproperty
  a_dat: assert property (p_dat) else $error("read data moved");
  property p_hold; hold_cnt < HOLD_CYC |-> alarm_out_o == 3'h0; endproperty
  a_hold: assert property (p_hold) else $error("output during hold");
  property p_one; $onehot0(current_sensor_one_o); endproperty
  a_one: assert property (p_one) else $error("sensor one not one-hot");
  property p_two; $onehot0(current_sensor_two_o); endproperty
  a_two: assert property (p_two) else $error("sensor two not one-hot");
  property p_sel;
    $changed({current_sensor_two_o, current_sensor_one_o}) |-> $past(wreq) || $past(wreq, 2);
  endproperty
  a_sel: assert property (p_sel) else $error("selector moved unasked");
endmodule : aop_postproc_asserts
bind aop_postproc aop_postproc_asserts #(.TICK_CYC(TICK_CYC), .HOLD_CYC(HOLD_CYC))
  aop_postproc_asserts_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
  .alarm_out_o(alarm_out_o), .current_sensor_one_o(current_sensor_one_o),
  .current_sensor_two_o(current_sensor_two_o));

// ---- verif/aop_relay_model.sv ----
`timescale 1ns/1ps
// Relay contacts: each closes one cycle after its pin drives it.
module aop_relay_model (
  input  wire logic       clk_i,
  input  wire logic [2:0] drive_i,
  output logic      [2:0] closed_o
);
  always_ff @(posedge clk_i)
  begin
    closed_o <= drive_i;
  end
endmodule : aop_relay_model

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack;
  logic [7:0] adr = 0;
  logic [31:0] wd = 0, rd, q;
  logic [2:0] ao, st, cl;
  logic [3:0] s1, s2;
  aop_pkg::aop_proc_s p = '0;
  int errors = 0, comparisons = 0;
  aop_postproc #(.TICK_CYC(10), .HOLD_CYC(20)) aop_postproc_inst (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_ack_o(ack), .wb_dat_o(q), .proc_i(p),
    .alarm_out_o(ao), .alarm_status_o(st), .current_sensor_one_o(s1),
    .current_sensor_two_o(s2));
  aop_relay_model aop_relay_model_inst (.clk_i(clk_i), .drive_i(ao), .closed_o(cl));
  initial forever #50 clk_i = ~clk_i;
  // One classic Wishbone cycle; read data is taken at the ack edge.
  task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      errors++;
      $display("Error %0t: no bus acknowledge", $time);
    end
    rd = q;
    cyc <= 0;
    stb <= 0;
  endtask : bus
  // Stops control, writes one setting, starts control again.
  task automatic cfg(input logic [7:0] a, input logic [31:0] d);
    bus(8'h00, 32'h10, 1);
    bus(a, d, 1);
    bus(8'h00, 32'h11, 1);
  endtask : cfg
  task automatic pv(input logic [15:0] v, input int c);
    @(posedge clk_i);
    p.pv <= v;
    repeat (c) @(posedge clk_i);
  endtask : pv
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin errors++; $display("Error %0t: got %h want %h", $time, g, e); end
  endtask : chk
  task automatic end_of_test;
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    bus(8'h10, 32'hA2, 1);
    repeat (16) @(posedge clk_i);
    chk(ao[0], 0);
    repeat (6) @(posedge clk_i);
    chk(ao[0], 1);
    bus(8'h10, 32'h02, 1);
    bus(8'h10, 0, 0); chk(rd[3:0], 4'h2);
    bus(8'h18, 0, 0); chk(rd[15:0], 16'h0002);
    bus(8'hFC, 0, 0); chk(rd, 0);
    bus(8'h0C, 32'h21, 1); bus(8'h0C, 32'h55, 1); chk({s2, s1}, 8'h21);
    bus(8'h00, 32'h11, 1); bus(8'h10, 32'h3, 1); bus(8'h10, 0, 0); chk(rd[3:0], 4'h2);
    cfg(8'h18, 0); bus(8'h18, 0, 0); chk(rd[15:0], 16'h0002);
    cfg(8'h14, 32'd100);
    pv(101, 6); chk(st[0], 1); chk(ao[0], 1);
    pv(99, 6); chk(st[0], 1);
    pv(97, 6); chk(st[0], 0);
    bus(8'h00, 32'h00, 1);
    bus(8'h00, 32'h00, 1);
    pv(16'h0065, 6);
    chk(st[0], 1);
    pv(16'h0063, 6);
    chk(st[0], 0);
    cfg(8'h1C, 32'h2); pv(101, 15); chk(st[0], 0);
    repeat (30) @(posedge clk_i); chk(st[0], 1);
    pv(97, 40); cfg(8'h1C, 0); cfg(8'h10, 32'h12);
    pv(101, 6); pv(97, 6); chk(st[0], 1);
    bus(8'h00, 32'h13, 1); repeat (6) @(posedge clk_i); chk(st[0], 0);
    cfg(8'h10, 32'hA2); repeat (6) @(posedge clk_i); chk(cl[0], 1);
    cfg(8'h10, 32'h22); repeat (6) @(posedge clk_i); chk(ao[0], 0);
    cfg(8'h10, 32'h00); pv(101, 6); chk(st[0], 0);
    cfg(8'h10, 32'h06); repeat (6) @(posedge clk_i); chk(st[0], 0);
    pv(97, 6); pv(101, 6); chk(st[0], 1);
    p.sp_target <= 16'h0001;
    repeat (6) @(posedge clk_i);
    chk(st[0], 0);
    cfg(8'h10, 32'h42);
    p.sp_target <= 16'h0032;
    p.ramp_en <= 1'b1;
    pv(16'h0078, 6);
    chk(st[0], 0);
    p.self_tune <= 1'b1;
    repeat (6) @(posedge clk_i);
    chk(st[0], 1);
    end_of_test();
  end
  initial
  begin
    repeat (3000) @(posedge clk_i);
    errors++;
    $display("Error %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule : tb_top
